// [ddsw_port.sv]
`timescale 1ns/1ps
`default_nettype none

package ddsw_pkg;
  // ****************************************
  // Frame layout
  // ****************************************
  localparam int WORD_W = 24;
  localparam int DATA_W = 16;
  localparam logic [4:0] WORD_BITS = 5'h18;
  localparam logic [4:0] LAST_BIT = 5'h17;
  localparam int RSV_MSB = 23;
  localparam int RSV_LSB = 22;
  localparam int LOADB_BIT = 21;
  localparam int LOADA_BIT = 20;
  localparam int SEL_BIT = 18;
  localparam int PD_MSB = 17;
  localparam int PD_LSB = 16;
  localparam int FIFO_DEPTH = 32;
  // Host-side gap after 24th edge, not enforced here
  localparam int GAP_NS = 100;
  localparam int CLK_NS = 5;
  localparam int GAP_CYC = (GAP_NS + CLK_NS - 1) / CLK_NS;
  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] CHAN_A_OFS = 8'h08;
  localparam logic [7:0] CHAN_B_OFS = 8'h0C;
  localparam logic [7:0] LAST_OFS = 8'h10;
  localparam logic [7:0] FRAMES_OFS = 8'h14;
  localparam logic [7:0] ABORTS_OFS = 8'h18;
  localparam int HOLD_BIT = 0;
  localparam int ST_EMPTY_BIT = 0;
  localparam int ST_FULL_BIT = 1;
  localparam int ST_OVF_BIT = 2;
  localparam int ST_RSV_BIT = 3;
  localparam int ST_ACTIVE_BIT = 4;
  localparam int CHAN_PD_LSB = 16;
endpackage

// Overview of operation
// - Low frame select enables the shift register; high select disables it.
// - In a frame, each of the first 24 falling serial clock edges shifts one data bit in.
// - Frame word is 24 bits: control byte first, then 16 data bits.
// - Command executes right after the 24th falling edge while hold is clear, not at select rise.
// - Select rising before 24 bits aborts; only the abort counter changes.
// - After 24 bits the shift register freezes for the rest of frame.
// - Bits 23:22 reserved zero, bit 20 loads A, bit 21 loads B.
// - Bit 18 picks channel; bits 17:16 pick normal or power-down mode.
// - Channel registers reset to zero, change only on a valid write.
module ddsw_port (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic frame_select_n,
  input wire logic serial_clock_in,
  input wire logic serial_data_in,
  output logic [15:0] chan_a_code,
  output logic [15:0] chan_b_code,
  output logic [1:0] chan_a_powerdown,
  output logic [1:0] chan_b_powerdown
);

  typedef struct packed {
    logic fs_m;
    logic fs_s;
    logic sck_m;
    logic sck_s;
    logic sck_d;
    logic sdi_m;
    logic sdi_s;
    logic [4:0] bit_cnt;
    logic [23:0] shift;
    logic hold;
    logic ovf;
    logic rsv_err;
    logic [15:0] buf_a;
    logic [15:0] buf_b;
    logic [1:0] bpd_a;
    logic [1:0] bpd_b;
    logic [15:0] chan_a;
    logic [15:0] chan_b;
    logic [1:0] pd_a;
    logic [1:0] pd_b;
    logic [23:0] last_word;
    logic [15:0] frame_cnt;
    logic [15:0] abort_cnt;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } ddsw_state_t;

  ddsw_state_t s;
  ddsw_state_t next_s;
  logic sck_fall;
  logic push;
  logic pop;
  logic [23:0] rx_word;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [23:0] fifo_word;
  logic [31:0] rd_val;
  logic rd_miss;

  // ****************************************
  // Command queue
  // ****************************************
  // Hold bit lets software stall execution; frames then pile up here
  ddsw_fifo #(
    .WIDTH(ddsw_pkg::WORD_W),
    .DEPTH(ddsw_pkg::FIFO_DEPTH)
  ) u_fifo (
    .pclk(pclk),
    .presetn(presetn),
    .in_valid(push),
    .in_ready(fifo_in_ready),
    .in_data(rx_word),
    .out_valid(fifo_out_valid),
    .out_ready(!s.hold),
    .out_data(fifo_word)
  );

  assign sck_fall = s.sck_d & ~s.sck_s;
  assign rx_word = {s.shift[ddsw_pkg::WORD_W-2:0], s.sdi_s};
  assign pop = fifo_out_valid & ~s.hold;

  always_comb begin
    rd_miss = 1'b0;
    rd_val = '0;
    unique case (paddr)
      ddsw_pkg::CTRL_OFS: rd_val[ddsw_pkg::HOLD_BIT] = s.hold;
      ddsw_pkg::STATUS_OFS: begin
        rd_val[ddsw_pkg::ST_EMPTY_BIT] = ~fifo_out_valid;
        rd_val[ddsw_pkg::ST_FULL_BIT] = ~fifo_in_ready;
        rd_val[ddsw_pkg::ST_OVF_BIT] = s.ovf;
        rd_val[ddsw_pkg::ST_RSV_BIT] = s.rsv_err;
        rd_val[ddsw_pkg::ST_ACTIVE_BIT] = ~s.fs_s;
      end
      ddsw_pkg::CHAN_A_OFS: rd_val = {14'h0000, s.pd_a, s.chan_a};
      ddsw_pkg::CHAN_B_OFS: rd_val = {14'h0000, s.pd_b, s.chan_b};
      ddsw_pkg::LAST_OFS: rd_val = {8'h00, s.last_word};
      ddsw_pkg::FRAMES_OFS: rd_val = {16'h0000, s.frame_cnt};
      ddsw_pkg::ABORTS_OFS: rd_val = {16'h0000, s.abort_cnt};
      default: rd_miss = 1'b1;
    endcase
  end

  always_comb begin
    next_s = s;
    push = 1'b0;
    // ****************************************
    // Pin synchronisers
    // ****************************************
    next_s.fs_m = frame_select_n;
    next_s.fs_s = s.fs_m;
    next_s.sck_m = serial_clock_in;
    next_s.sck_s = s.sck_m;
    next_s.sck_d = s.sck_s;
    next_s.sdi_m = serial_data_in;
    next_s.sdi_s = s.sdi_m;
    // ****************************************
    // APB slave, one wait state
    // ****************************************
    next_s.pready = 1'b0;
    next_s.pslverr = 1'b0;
    next_s.prdata = '0;
    if (psel && penable && !s.pready) begin
      next_s.pready = 1'b1;
      next_s.pslverr = rd_miss;
      next_s.prdata = rd_val;
    end
    if (psel && penable && s.pready && pwrite) begin
      if (paddr == ddsw_pkg::CTRL_OFS) begin
        next_s.hold = pwdata[ddsw_pkg::HOLD_BIT];
      end
      // Clear first so a same-cycle event below wins
      if (paddr == ddsw_pkg::STATUS_OFS) begin
        if (pwdata[ddsw_pkg::ST_OVF_BIT]) begin
          next_s.ovf = 1'b0;
        end
        if (pwdata[ddsw_pkg::ST_RSV_BIT]) begin
          next_s.rsv_err = 1'b0;
        end
      end
    end
    // ****************************************
    // Serial receiver
    // ****************************************
    if (s.fs_s) begin
      if (s.bit_cnt != '0 && s.bit_cnt < ddsw_pkg::WORD_BITS) begin
        next_s.abort_cnt = s.abort_cnt + 16'h0001;
      end
      next_s.bit_cnt = '0;
      next_s.shift = '0;
    end else if (sck_fall && s.bit_cnt < ddsw_pkg::WORD_BITS) begin
      // Counter stops at 24, which freezes the shifter
      next_s.shift = rx_word;
      next_s.bit_cnt = s.bit_cnt + 5'h01;
      if (s.bit_cnt == ddsw_pkg::LAST_BIT) begin
        push = 1'b1;
        if (fifo_in_ready) begin
          next_s.last_word = rx_word;
          next_s.frame_cnt = s.frame_cnt + 16'h0001;
        end else begin
          // Source cannot be stalled; a full queue drops the frame
          next_s.ovf = 1'b1;
        end
      end
    end
    // ****************************************
    // Command execution
    // ****************************************
    if (pop) begin
      if (fifo_word[ddsw_pkg::RSV_MSB:ddsw_pkg::RSV_LSB] != 2'h0) begin
        next_s.rsv_err = 1'b1;
      end else begin
        if (fifo_word[ddsw_pkg::SEL_BIT]) begin
          next_s.buf_b = fifo_word[ddsw_pkg::DATA_W-1:0];
          next_s.bpd_b = fifo_word[ddsw_pkg::PD_MSB:ddsw_pkg::PD_LSB];
        end else begin
          next_s.buf_a = fifo_word[ddsw_pkg::DATA_W-1:0];
          next_s.bpd_a = fifo_word[ddsw_pkg::PD_MSB:ddsw_pkg::PD_LSB];
        end
        if (fifo_word[ddsw_pkg::LOADA_BIT]) begin
          next_s.chan_a = next_s.buf_a;
          next_s.pd_a = next_s.bpd_a;
        end
        if (fifo_word[ddsw_pkg::LOADB_BIT]) begin
          next_s.chan_b = next_s.buf_b;
          next_s.pd_b = next_s.bpd_b;
        end
      end
    end
  end

  // Zero reset puts both channels at zero-scale
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign chan_a_code = s.chan_a;
  assign chan_b_code = s.chan_b;
  assign chan_a_powerdown = s.pd_a;
  assign chan_b_powerdown = s.pd_b;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_bit_edge;
    !s.fs_s && sck_fall && s.bit_cnt < ddsw_pkg::WORD_BITS;
  endsequence

  sequence s_last_edge;
    s_bit_edge ##0 s.bit_cnt == ddsw_pkg::LAST_BIT;
  endsequence

  sequence s_good_pop;
    pop && fifo_word[ddsw_pkg::RSV_MSB:ddsw_pkg::RSV_LSB] == 2'h0;
  endsequence

  frame_idle_a: assert property (
    s.fs_s |=> s.bit_cnt == 5'h00 && s.shift == 24'h000000)
    else $error("counter not cleared while frame idle");

  bit_shift_a: assert property (
    s_bit_edge |=> s.bit_cnt == $past(s.bit_cnt) + 5'h01
      && s.shift[0] == $past(s.sdi_s))
    else $error("falling edge did not shift one bit");

  word_freeze_a: assert property (
    !s.fs_s && s.bit_cnt == ddsw_pkg::WORD_BITS |=> $stable(s.shift))
    else $error("shift register changed after 24 bits");

  word_push_a: assert property (
    s_last_edge ##0 fifo_in_ready |=> s.last_word == $past(rx_word)
      && s.frame_cnt == $past(s.frame_cnt) + 16'h0001)
    else $error("word not queued at 24th edge");

  abort_keep_a: assert property (
    s.fs_s && s.bit_cnt != 5'h00 && s.bit_cnt < ddsw_pkg::WORD_BITS
    |=> s.abort_cnt == $past(s.abort_cnt) + 16'h0001 && !$past(push))
    else $error("aborted frame not discarded");

  load_a_a: assert property (
    s_good_pop ##0 fifo_word[ddsw_pkg::LOADA_BIT]
      && !fifo_word[ddsw_pkg::SEL_BIT]
    |=> s.chan_a == $past(fifo_word[ddsw_pkg::DATA_W-1:0]))
    else $error("load of channel A lost");

  reserved_drop_a: assert property (
    pop && fifo_word[ddsw_pkg::RSV_MSB:ddsw_pkg::RSV_LSB] != 2'h0
    |=> $stable(s.chan_a) && $stable(s.chan_b) && s.rsv_err)
    else $error("reserved bits set but command ran");

  select_b_a: assert property (
    s_good_pop ##0 fifo_word[ddsw_pkg::SEL_BIT]
    |=> s.buf_b == $past(fifo_word[ddsw_pkg::DATA_W-1:0])
      && s.bpd_b == $past(fifo_word[ddsw_pkg::PD_MSB:ddsw_pkg::PD_LSB])
      && $stable(s.buf_a))
    else $error("channel select misrouted data");

  chan_quiet_a: assert property (
    !pop |=> $stable(s.chan_a) && $stable(s.chan_b))
    else $error("channel changed without a command");

  ovf_sticky_a: assert property (
    s_last_edge ##0 !fifo_in_ready |=> s.ovf [*2])
    else $error("overflow flag not held");

endmodule

`default_nettype wire

// [ddsw_fifo.sv]
`timescale 1ns/1ps
`default_nettype none

module ddsw_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 32
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_COUNT = (AW+1)'(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
  } ddsw_fifo_state_t;

  ddsw_fifo_state_t s;
  ddsw_fifo_state_t next_s;
  logic [WIDTH-1:0] mem [DEPTH];
  logic do_wr;
  logic do_rd;

  assign in_ready = (s.count != FULL_COUNT);
  assign out_valid = (s.count != '0);
  assign out_data = mem[s.rd_ptr];
  assign do_wr = in_valid & in_ready;
  assign do_rd = out_valid & out_ready;

  always_comb begin
    next_s = s;
    if (do_wr) begin
      next_s.wr_ptr = (s.wr_ptr == AW'(DEPTH - 1)) ? '0 : s.wr_ptr + 1'b1;
    end
    if (do_rd) begin
      next_s.rd_ptr = (s.rd_ptr == AW'(DEPTH - 1)) ? '0 : s.rd_ptr + 1'b1;
    end
    next_s.count = s.count + (AW+1)'(do_wr) - (AW+1)'(do_rd);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // Storage needs no reset; empty flag guards stale words
  always_ff @(posedge pclk) begin
    if (do_wr) begin
      mem[s.wr_ptr] <= in_data;
    end
  end

  count_bound_a: assert property (@(posedge pclk) disable iff (!presetn)
    s.count <= FULL_COUNT)
    else $error("fifo count beyond depth");

endmodule

`default_nettype wire

// [ddsw_host_model.sv]
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// Serial host model
// ****************************************
module ddsw_host (
  output logic frame_select_n,
  output logic serial_clock_in,
  output logic serial_data_in
);
  // Clock idles high and stands still between frames
  initial begin
    frame_select_n = 1'b1;
    serial_clock_in = 1'b1;
    serial_data_in = 1'b0;
  end

  // MSB first; returns with the frame still selected
  // The 1 ns offset keeps every pin edge off a pclk edge
  task automatic send(input logic [23:0] w, input int n);
    #1;
    frame_select_n = 1'b0;
    #62.5;
    for (int i = 0; i < n; i++) begin
      serial_data_in = w[23 - (i % 24)];
      #62.5 serial_clock_in = 1'b0;
      #62.5 serial_clock_in = 1'b1;
    end
  endtask

  // Undriven data shows the inverse, never a stale bit
  task automatic end_frame();
    #1;
    #100;
    frame_select_n = 1'b1;
    serial_data_in = ~serial_data_in;
    #250;
  endtask
endmodule

`default_nettype wire

// [tb_dual_dac_serial_write_port.sv]
`timescale 1ns/1ps
`default_nettype none

module tb_dual_dac_serial_write_port;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  wire frame_select_n;
  wire serial_clock_in;
  wire serial_data_in;
  logic [15:0] chan_a_code;
  logic [15:0] chan_b_code;
  logic [1:0] chan_a_powerdown;
  logic [1:0] chan_b_powerdown;
  logic [32:0] exp_q[$];
  int failures = 0;
  int n_tests = 0;
  logic [15:0] d;
  logic [15:0] e;
  logic [1:0] pd;

  always #2.5 pclk = ~pclk;

  ddsw_port u_ddsw_port (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .frame_select_n(frame_select_n),
    .serial_clock_in(serial_clock_in), .serial_data_in(serial_data_in),
    .chan_a_code(chan_a_code), .chan_b_code(chan_b_code),
    .chan_a_powerdown(chan_a_powerdown), .chan_b_powerdown(chan_b_powerdown)
  );

  ddsw_host u_ddsw_host (
    .frame_select_n(frame_select_n),
    .serial_clock_in(serial_clock_in),
    .serial_data_in(serial_data_in)
  );

  // ****************************************
  // Checking and bus tasks
  // ****************************************
  task automatic check(input string nm, input logic [32:0] seen,
                       input logic [32:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s exp=%h seen=%h", nm, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] dt);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= dt;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Expected value is {slave error, read data}
  task automatic rd(input logic [7:0] a, input logic [32:0] ex);
    exp_q.push_back(ex);
    apb(1'b0, a, 32'h0);
  endtask

  task automatic frame(input logic [23:0] w, input int n);
    u_ddsw_host.send(w, n);
    u_ddsw_host.end_frame();
    repeat (12) @(posedge pclk);
  endtask

  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      if (exp_q.size() == 0) begin
        check("unexpected_read", 33'h0, 33'h1);
      end else begin
        check("apb_read", {pslverr, prdata}, exp_q.pop_front());
      end
    end
  end

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    void'($urandom(23305));
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    rd(ddsw_pkg::CHAN_A_OFS, 33'h0);
    rd(ddsw_pkg::CHAN_B_OFS, 33'h0);
    rd(ddsw_pkg::STATUS_OFS, 33'h1);
    rd(8'h1C, 33'h1_0000_0000);
    $display("test reset done");
    // Control 18: load A, channel A; bit 19 set as it must be ignored
    d = 16'($urandom);
    u_ddsw_host.send({8'h18, d}, 26);
    repeat (12) @(posedge pclk);
    check("chan_a_code", {17'h0, chan_a_code}, {17'h0, d});
    u_ddsw_host.end_frame();
    rd(ddsw_pkg::CHAN_A_OFS, {17'h0, d});
    pd = 2'($urandom);
    e = 16'($urandom);
    frame({6'h0B, pd, e}, 24);
    rd(ddsw_pkg::CHAN_B_OFS, {15'h0, pd, e});
    check("chan_b_pd", {31'h0, chan_b_powerdown}, {31'h0, pd});
    rd(ddsw_pkg::CHAN_A_OFS, {17'h0, d});
    $display("test load done");
    // Buffer only, then load A while data goes to buffer B
    frame({8'h09, e}, 24);
    rd(ddsw_pkg::CHAN_A_OFS, {17'h0, d});
    frame({8'h1C, d}, 24);
    rd(ddsw_pkg::CHAN_A_OFS, {15'h0, 2'h1, e});
    // Both loads at once: B takes new data, A reloads its buffer
    frame({8'h34, ~e}, 24);
    check("chan_b_code", {17'h0, chan_b_code}, {17'h0, ~e});
    check("chan_a_pd", {31'h0, chan_a_powerdown}, 33'h1);
    $display("test buffer done");
    // One bit short of a frame
    frame({8'h18, 16'hFFFF}, 23);
    rd(ddsw_pkg::CHAN_A_OFS, {15'h0, 2'h1, e});
    rd(ddsw_pkg::ABORTS_OFS, 33'h1);
    frame({8'h1B, d}, 24);
    rd(ddsw_pkg::CHAN_A_OFS, {15'h0, 2'h3, d});
    $display("test abort done");
    frame({8'h98, 16'h0}, 24);
    rd(ddsw_pkg::CHAN_A_OFS, {15'h0, 2'h3, d});
    rd(ddsw_pkg::STATUS_OFS, 33'h9);
    apb(1'b1, ddsw_pkg::STATUS_OFS, 32'h8);
    rd(ddsw_pkg::STATUS_OFS, 33'h1);
    $display("test reserved done");
    // Stall the decoder, overfill the FIFO, then drain it
    apb(1'b1, ddsw_pkg::CTRL_OFS, 32'h1);
    rd(ddsw_pkg::CTRL_OFS, 33'h1);
    for (int i = 0; i < 33; i++) begin
      frame({8'h18, 16'(i)}, 24);
    end
    rd(ddsw_pkg::STATUS_OFS, 33'h6);
    rd(ddsw_pkg::CHAN_A_OFS, {15'h0, 2'h3, d});
    apb(1'b1, ddsw_pkg::CTRL_OFS, 32'h0);
    repeat (200) @(posedge pclk);
    rd(ddsw_pkg::STATUS_OFS, 33'h5);
    rd(ddsw_pkg::CHAN_A_OFS, 33'h1F);
    rd(ddsw_pkg::FRAMES_OFS, 33'h27);
    $display("test fifo done");
    tally_and_finish();
  end

  // Run needs about 144 us
  initial begin
    #400000;
    failures++;
    tally_and_finish();
  end
endmodule

`default_nettype wire
